// >>> design/diag_event_reporter.sv
/*
  Diagnostic event reporter: queues fault events and presents the oldest one as a code
  word with coming/going flag and class, stepping on host acknowledge.
  Assumes a plain register port driven on ref_clk and asynchronous fault pins.
*/
// Local design decisions: the address map and the plain strobed port.
module diag_event_reporter #(
  parameter int unsigned WD_DELAY_CYCLES = der_pkg::WD_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic volFlowOverflow,
  input wire logic zeroSigmaOver,
  input wire logic zeroOffsetOver,
  input wire logic totalizerCrcFail,
  input wire logic framFault,
  input wire logic dramFault,
  input wire logic watchdogRestart,
  input wire logic codeFaultRestart,
  input wire logic procIrqLost,
  input wire logic moduleDataCrcFail,
  input wire logic lifebitTimeout,
  input wire logic serialCommError,
  input wire logic underVoltage,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [7:0] eventCodeWord,
  output logic [7:0] eventClassField,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    der_pkg::der_phase_e phase;
    logic [6:0] curNum;
    logic [7:0] codeWord;
    logic [7:0] classF;
    logic [der_pkg::Q_DEPTH-1:0][6:0] queue;
    logic [der_pkg::Q_AW-1:0] wrPtr;
    logic [der_pkg::Q_AW-1:0] rdPtr;
    logic [der_pkg::Q_AW:0] count;
    logic [der_pkg::N_COND-1:0] condPrev;
    logic [der_pkg::N_COND-1:0] pend;
    logic ackLvl;
    logic ackPrev;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic [31:0] rdata;
    logic [der_pkg::WD_CNT_W-1:0] wdCnt;
    logic wdStrap;
  } der_state_s;

  localparam logic [der_pkg::WD_CNT_W-1:0] WD_LIMIT = WD_DELAY_CYCLES[der_pkg::WD_CNT_W-1:0];
  localparam logic [der_pkg::WD_CNT_W-1:0] WD_FIRE_AT = WD_LIMIT - 27'h0000001;
  localparam logic [der_pkg::Q_AW:0] Q_FULL = 5'h10;

  der_state_s r_ff;
  der_state_s nxt_r;
  logic [der_pkg::N_COND-1:0] condStable;
  logic [der_pkg::N_COND-1:0] raise;
  logic [der_pkg::N_COND-1:0] pendAll;
  logic ackPulse;
  logic wdFire;
  logic doPop;
  logic doPush;
  logic dropEvt;
  logic pendHit;
  logic [3:0] pendIdx;
  logic [6:0] popNum;
  logic [1:0] statSet;
  logic [1:0] statClr;

  der_sync_if #(.W(der_pkg::N_COND)) condIf ();

  // ----------------------------------------------------------------
  // Fault inputs
  // ----------------------------------------------------------------
  // Vector position i carries diagnostic 28 + i; position 6 carries the restart strap.
  assign condIf.raw = {underVoltage, serialCommError, lifebitTimeout, moduleDataCrcFail,
                       procIrqLost, codeFaultRestart, watchdogRestart, dramFault, framFault,
                       totalizerCrcFail, zeroOffsetOver, zeroSigmaOver, volFlowOverflow};

  der_in_sync #(.W(der_pkg::N_COND)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sif(condIf)
  );

  assign condStable = condIf.stable;

  function automatic logic [7:0] classOf(input logic [6:0] num);
    classOf = (num <= der_pkg::NUM_LAST_PE) ? der_pkg::CLASS_PE : der_pkg::CLASS_SE;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    doPop = 1'b0;
    doPush = 1'b0;
    dropEvt = 1'b0;
    pendHit = 1'b0;
    pendIdx = 4'h0;
    statSet = 2'h0;
    statClr = 2'h0;
    popNum = r_ff.queue[r_ff.rdPtr];

    // A held acknowledge bit yields one pulse only.
    ackPulse = r_ff.ackLvl & ~r_ff.ackPrev;
    nxt_r.ackPrev = r_ff.ackLvl;

    // Startup timer; the strap is caught once the synchroniser has settled after reset.
    if (r_ff.wdCnt != WD_LIMIT) begin
      nxt_r.wdCnt = r_ff.wdCnt + 27'h0000001;
    end
    if (r_ff.wdCnt == der_pkg::SYNC_LAT) begin
      nxt_r.wdStrap = condStable[der_pkg::WDOG_IDX];
    end
    wdFire = r_ff.wdStrap && (r_ff.wdCnt == WD_FIRE_AT);

    // Rising conditions become pending; the strap level itself raises nothing.
    nxt_r.condPrev = condStable;
    raise = condStable & ~r_ff.condPrev;
    raise[der_pkg::WDOG_IDX] = wdFire;
    pendAll = r_ff.pend | raise;

    // Lowest pending diagnostic enters the queue first, one per cycle.
    for (int i = der_pkg::N_COND - 1; i >= 0; i--) begin
      if (r_ff.pend[i]) begin
        pendHit = 1'b1;
        pendIdx = 4'(i);
      end
    end

    // Presentation sequence.
    case (r_ff.phase)
      der_pkg::PH_IDLE: begin
        if (r_ff.count != 5'h00) begin
          doPop = 1'b1;
        end
      end
      der_pkg::PH_COMING: begin
        if (ackPulse) begin
          nxt_r.phase = der_pkg::PH_GOING;
          nxt_r.codeWord = {1'b0, r_ff.curNum};
        end
      end
      der_pkg::PH_GOING: begin
        if (ackPulse) begin
          if (r_ff.count != 5'h00) begin
            doPop = 1'b1;
          end else begin
            nxt_r.phase = der_pkg::PH_IDLE;
            nxt_r.codeWord = der_pkg::CODE_RST;
            nxt_r.classF = 8'h00;
          end
        end
      end
      default: begin
        nxt_r.phase = der_pkg::PH_IDLE;
        nxt_r.codeWord = der_pkg::CODE_RST;
        nxt_r.classF = 8'h00;
      end
    endcase

    if (doPop) begin
      nxt_r.phase = der_pkg::PH_COMING;
      nxt_r.curNum = popNum;
      nxt_r.codeWord = {1'b1, popNum};
      nxt_r.classF = classOf(popNum);
      nxt_r.rdPtr = r_ff.rdPtr + 4'h1;
    end

    // Queue entry; a full queue drops the event and flags an overflow, unless a pop in the same cycle frees a slot.
    if (pendHit) begin
      pendAll[pendIdx] = 1'b0;
      if ((r_ff.count != Q_FULL) || doPop) begin
        doPush = 1'b1;
        nxt_r.queue[r_ff.wrPtr] = der_pkg::NUM_BASE + 7'(pendIdx);
        nxt_r.wrPtr = r_ff.wrPtr + 4'h1;
      end else begin
        dropEvt = 1'b1;
      end
    end
    nxt_r.pend = pendAll | (raise & ~r_ff.pend);
    nxt_r.count = r_ff.count + 5'(doPush) - 5'(doPop);

    // Register writes.
    if (regWr) begin
      case (regAddr)
        der_pkg::ADDR_ACK: nxt_r.ackLvl = regWdata[der_pkg::ACK_BIT];
        der_pkg::ADDR_IRQ_STAT: statClr = regWdata[1:0];
        der_pkg::ADDR_IRQ_MASK: nxt_r.mask = regWdata[1:0];
        default: begin
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear.
    statSet[der_pkg::STAT_NEW] = doPush;
    statSet[der_pkg::STAT_OVF] = dropEvt;
    nxt_r.stat = (r_ff.stat & ~statClr) | statSet;
    nxt_r.irq = |(nxt_r.stat & nxt_r.mask);

    // Read data stands for the one cycle after the strobe.
    nxt_r.rdata = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        der_pkg::ADDR_EVENT: begin
          nxt_r.rdata[der_pkg::EVT_CODE_LSB +: 8] = r_ff.codeWord;
          nxt_r.rdata[der_pkg::EVT_CLASS_LSB +: 8] = r_ff.classF;
        end
        der_pkg::ADDR_ACK: nxt_r.rdata[der_pkg::ACK_BIT] = r_ff.ackLvl;
        der_pkg::ADDR_IRQ_STAT: nxt_r.rdata[1:0] = r_ff.stat;
        der_pkg::ADDR_IRQ_MASK: nxt_r.rdata[1:0] = r_ff.mask;
        der_pkg::ADDR_COND: nxt_r.rdata[der_pkg::N_COND-1:0] = condStable;
        default: nxt_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_ff <= '0;
      r_ff.phase <= der_pkg::PH_IDLE;
      r_ff.codeWord <= der_pkg::CODE_RST;
      r_ff.mask <= der_pkg::MASK_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata = r_ff.rdata;
  assign eventCodeWord = r_ff.codeWord;
  assign eventClassField = r_ff.classF;
  assign irq = r_ff.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_coming_flag_set: assert property (
    (r_ff.phase == der_pkg::PH_COMING) |->
      (eventCodeWord == {1'b1, r_ff.curNum}))
    else $error("coming code word lacks flag or number");

  a_class_process: assert property (
    (r_ff.phase != der_pkg::PH_IDLE) && (r_ff.curNum <= der_pkg::NUM_LAST_PE) |->
      (eventClassField == der_pkg::CLASS_PE))
    else $error("process class not shown for process diagnostic");

  a_coming_held: assert property (
    (r_ff.phase == der_pkg::PH_COMING) && !ackPulse |=> $stable(eventCodeWord))
    else $error("coming code word changed without acknowledge");

  a_ack_going: assert property (
    (r_ff.phase == der_pkg::PH_COMING) && ackPulse |=>
      (eventCodeWord == {1'b0, $past(eventCodeWord[6:0])}) && r_ff.phase == der_pkg::PH_GOING)
    else $error("acknowledge did not turn coming into going");

  a_going_empty: assert property (
    (r_ff.phase == der_pkg::PH_GOING) && ackPulse && (r_ff.count == 5'h00) |=>
      ((eventCodeWord == 8'h00) && (eventClassField == 8'h00)) ##1
      ((eventCodeWord == 8'h00) || ($past(r_ff.count) != 5'h00)))
    else $error("empty queue did not present zero");

  a_going_next: assert property (
    (r_ff.phase == der_pkg::PH_GOING) && ackPulse && (r_ff.count != 5'h00) |=>
      eventCodeWord[der_pkg::COMING_BIT] && (eventCodeWord[6:0] == $past(popNum)))
    else $error("next queued event not presented");

  a_wdog_time: assert property (
    $rose(r_ff.pend[der_pkg::WDOG_IDX]) |-> (r_ff.wdCnt == WD_LIMIT) && r_ff.wdStrap)
    else $error("watchdog diagnostic raised outside the startup delay");

  a_crc_pending: assert property (
    $rose(condStable[3]) |=> r_ff.pend[3])
    else $error("totalizer crc fault not queued");

  a_irq_lost_pending: assert property (
    $rose(condStable[8]) |=> r_ff.pend[8])
    else $error("lost interrupt fault not queued");

  a_lifebit_pending: assert property (
    $rose(condStable[10]) |=> r_ff.pend[10])
    else $error("lifebit timeout not queued");

  a_flow_pending: assert property (
    $rose(condStable[0]) |=> r_ff.pend[0])
    else $error("flow overflow not queued");

  a_ack_edge_only: assert property (
    r_ff.ackPrev && (r_ff.phase != der_pkg::PH_IDLE) |=> $stable(eventCodeWord))
    else $error("held acknowledge produced a further step");

  c_coming: cover property ((r_ff.phase == der_pkg::PH_COMING) && ackPulse);
  c_going_next: cover property ((r_ff.phase == der_pkg::PH_GOING) && ackPulse && doPop);
  c_overflow: cover property (dropEvt);
  c_wdog: cover property (wdFire);

endmodule

// >>> design/der_pkg.sv
/*
  Constants, register map and types of the diagnostic event reporter.
  Assumes a single 25 MHz module clock and an active-low asynchronous reset.
*/
// Functional notes
// - The event code word holds the diagnostic number in bits 6:0 and bit 7 is set while coming.
// - The class field shows 2 for a process error and the system class value otherwise.
// - A presented coming code word stays unchanged until the host acknowledges it.
// - The host sets the acknowledge bit and the device then clears bit 7 to show going.
// - Acknowledging a going event presents the next queued event, or zero if none remains.
// - After a watchdog restart, diagnostic 34 is raised three seconds into startup.
// - A failed CRC check of the stored totalizer values raises diagnostic 31.
// - A lost process interrupt towards the host raises diagnostic 36.
// - A missing host lifebit within the monitoring timeout raises diagnostic 38.
// - Zero deviation above its limit raises 29 and zero offset above its limit raises 30.
// - An overflow of the volume-flow calculation raises diagnostic 28.
// - A startup after a code checksum failure or illegal execution raises diagnostic 35.
// - A wrong checksum over the stored module data raises diagnostic 37.
// - A serial communication error raises diagnostic 39.
// - An undervoltage indication of the internal supply raises diagnostic 40.
package der_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned WD_DELAY_MS = 3000;
  localparam int unsigned WD_DELAY_CYC = (CLK_HZ / 1000) * WD_DELAY_MS;
  localparam int unsigned WD_CNT_W = 27;
  // The stable level first shows at the fourth edge after release, so the strap is taken one later.
  localparam logic [26:0] SYNC_LAT = 27'h0000004;

  // ----------------------------------------------------------------
  // Diagnostics and code word
  // ----------------------------------------------------------------
  localparam int N_COND = 13;
  localparam int WDOG_IDX = 6;
  localparam logic [6:0] NUM_BASE = 7'h1C;
  localparam logic [6:0] NUM_LAST_PE = 7'h1F;
  localparam int COMING_BIT = 7;
  localparam logic [7:0] CLASS_PE = 8'h02;
  // System class value is arbitrary.
  localparam logic [7:0] CLASS_SE = 8'h01;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam int Q_DEPTH = 16;
  localparam int Q_AW = 4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT = 8'h00;
  localparam logic [7:0] ADDR_ACK = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_COND = 8'h10;
  localparam int EVT_CODE_LSB = 0;
  localparam int EVT_CLASS_LSB = 8;
  localparam int ACK_BIT = 0;
  localparam int STAT_NEW = 0;
  localparam int STAT_OVF = 1;
  localparam logic [1:0] MASK_RST = 2'h0;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_COMING = 2'b01,
    PH_GOING = 2'b10
  } der_phase_e;

endpackage

// >>> design/der_sync_if.sv
/*
  Carrier between the reporter and its input synchroniser.
  Assumes both ends share the module clock.
*/
interface der_sync_if #(
  parameter int W = 13
) ();
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport drv (output raw, input stable);
  modport syn (input raw, output stable);
endinterface

// >>> design/der_in_sync.sv
/*
  Three-stage synchroniser for fault pins; a level is taken once stages two and three agree.
  Assumes pins may change at any time relative to ref_clk.
*/
module der_in_sync #(
  parameter int W = 13
) (
  input wire logic ref_clk,
  input wire logic rstn,
  der_sync_if.syn sif
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } der_sync_s;

  der_sync_s r_ff;
  der_sync_s nxt_r;
  logic [W-1:0] agreeVal;

  // ----------------------------------------------------------------
  // Per-bit agreement
  // ----------------------------------------------------------------
  // The first stage feeds only the second, so a metastable sample never reaches a gate.
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agreeVal[i] = (r_ff.ff2[i] == r_ff.ff3[i]) ? r_ff.ff3[i] : r_ff.stable[i];
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.ff1 = sif.raw;
    nxt_r.ff2 = r_ff.ff1;
    nxt_r.ff3 = r_ff.ff2;
    nxt_r.stable = agreeVal;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sif.stable = r_ff.stable;

endmodule

// >>> verif/der_host_model.sv
/*
  Host controller model: masters the register port of the reporter.
  Assumes the bench calls its tasks one at a time and that the slave never stalls.
*/
module der_host_model (
  input wire logic ref_clk,
  output logic [7:0] regAddr,
  output logic [31:0] regWdata,
  output logic regWr,
  output logic regRd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
  endtask

  // Writing one twice and only then zero proves a held bit does not step twice.
  task automatic ack();
    wr(der_pkg::ADDR_ACK, {31'($urandom()), 1'b1});
    wr(der_pkg::ADDR_ACK, {31'($urandom()), 1'b1});
    wr(der_pkg::ADDR_ACK, {31'($urandom()), 1'b0});
  endtask
endmodule

// >>> verif/diag_event_reporter_bench.sv
/*
  Self-checking bench of the diagnostic event reporter.
  Assumes the host model drives the register port and the bench drives the fault pins.
*/
module diag_event_reporter_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int unsigned WDC = 20;
  logic ref_clk;
  logic rstn;
  logic irq;
  logic rdSeen;
  logic [12:0] flt;
  logic [7:0] regAddr;
  logic [7:0] eventCodeWord;
  logic [7:0] eventClassField;
  logic [31:0] regWdata;
  logic [31:0] regRdata;
  logic regWr;
  logic regRd;
  logic [15:0] lastOut;
  logic [15:0] expQ[$];
  logic [31:0] rdQ[$];
  logic [12:0] m;
  logic [7:0] ua;
  int miscompares;
  int checks;

  der_host_model h (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd));

  diag_event_reporter #(.WD_DELAY_CYCLES(WDC)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .volFlowOverflow(flt[0]), .zeroSigmaOver(flt[1]),
    .zeroOffsetOver(flt[2]), .totalizerCrcFail(flt[3]), .framFault(flt[4]),
    .dramFault(flt[5]), .watchdogRestart(flt[6]), .codeFaultRestart(flt[7]),
    .procIrqLost(flt[8]), .moduleDataCrcFail(flt[9]), .lifebitTimeout(flt[10]),
    .serialCommError(flt[11]), .underVoltage(flt[12]), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .eventCodeWord(eventCodeWord), .eventClassField(eventClassField), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Counts: checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] word(input int k, input logic c);
    logic [6:0] n;
    n = der_pkg::NUM_BASE + 7'(k);
    return {(n <= der_pkg::NUM_LAST_PE) ? der_pkg::CLASS_PE : der_pkg::CLASS_SE, c, n};
  endfunction

  task automatic waitq(input int left);
    int n;
    n = 0;
    while (expQ.size() > left && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (expQ.size() > left) begin
      miscompares++;
      $display("MISMATCH event queue expected %0d seen %0d", left, expQ.size());
      stop_test();
    end
  endtask

  // Every change of the shown word must match the oldest note; a change nobody noted fails.
  always @(negedge ref_clk) begin
    if (rstn === 1'b1 && {eventClassField, eventCodeWord} !== lastOut) begin
      if (expQ.size() == 0) begin
        checks++;
        miscompares++;
        $display("MISMATCH event word expected none seen %h", eventCodeWord);
      end else begin
        check("event word", {16'h0, expQ.pop_front()}, {16'h0, eventClassField, eventCodeWord});
      end
    end
    lastOut = {eventClassField, eventCodeWord};
    if (rdSeen) check("read data", rdQ.pop_front(), regRdata);
    rdSeen = regRd;
  end

  // Steps through the noted words once the first is shown, leaving each idle for a while first.
  task automatic steps();
    int k;
    k = expQ.size();
    flt <= 13'h0;
    while (k > 0) begin
      repeat (6) @(posedge ref_clk);
      h.ack();
      k--;
      waitq(k);
    end
  endtask

  task automatic burst(input logic [12:0] mk);
    int k;
    for (k = 12; k >= 0; k--) if (mk[k]) rdQ.push_front({16'h0, word(k, 1'b1)});
    for (k = 0; k < 13; k++) if (mk[k]) begin
      expQ.push_back(word(k, 1'b1));
      expQ.push_back(word(k, 1'b0));
    end
    expQ.push_back(16'h0);
    k = rdQ.size();
    while (rdQ.size() > 1) void'(rdQ.pop_back());
    flt <= mk;
    waitq(expQ.size() - 1);
    h.rd(der_pkg::ADDR_EVENT);
    rdQ.push_back({19'h0, mk});
    h.rd(der_pkg::ADDR_COND);
    steps();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    flt = 13'h0040;
    rdSeen = 1'b0;
    lastOut = 16'h0;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'h77ae));
    expQ.push_back(word(6, 1'b1));
    expQ.push_back(word(6, 1'b0));
    expQ.push_back(16'h0);
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    waitq(2);
    steps();
    $display("Test watchdog restart done");
    rdQ.push_back(32'h0);
    h.rd(der_pkg::ADDR_IRQ_MASK);
    rdQ.push_back(32'h1);
    h.rd(der_pkg::ADDR_IRQ_STAT);
    check("irq masked", 32'h0, {31'h0, irq});
    h.wr(der_pkg::ADDR_IRQ_MASK, {30'($urandom()), 2'h3});
    repeat (2) @(posedge ref_clk);
    check("irq", 32'h1, {31'h0, irq});
    rdQ.push_back(32'h3);
    h.rd(der_pkg::ADDR_IRQ_MASK);
    h.wr(der_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    ua = {1'b1, 7'($urandom())};
    h.wr(der_pkg::ADDR_ACK, {31'($urandom()), 1'b1});
    h.wr(ua, $urandom());
    h.wr(der_pkg::ADDR_EVENT, $urandom());
    rdQ.push_back(32'h0);
    h.rd(der_pkg::ADDR_IRQ_STAT);
    rdQ.push_back(32'h1);
    h.rd(der_pkg::ADDR_ACK);
    rdQ.push_back(32'h0);
    h.rd(ua);
    rdQ.push_back(32'h0);
    h.rd(der_pkg::ADDR_EVENT);
    h.wr(der_pkg::ADDR_ACK, 32'h0);
    $display("Test registers and interrupt done");
    for (int i = 0; i < 13; i++) if (i != 6) burst(13'h1 << i);
    $display("Test single conditions done");
    repeat (4) begin
      m = 13'($urandom()) & 13'h1FBF;
      if (m == 13'h0) m = 13'h1;
      burst(m);
    end
    $display("Test random bursts done");
    m = 13'h1FBF;
    for (int i = 0; i < 13; i++) if (m[i]) begin
      expQ.push_back(word(i, 1'b1));
      expQ.push_back(word(i, 1'b0));
    end
    // Sixteen slots and the shown word hold 17 events; the other seven are dropped.
    for (int i = 0; i < 5; i++) begin
      expQ.push_back(word(i, 1'b1));
      expQ.push_back(word(i, 1'b0));
    end
    expQ.push_back(16'h0);
    flt <= m;
    repeat (30) @(posedge ref_clk);
    flt <= 13'h0;
    repeat (10) @(posedge ref_clk);
    flt <= m;
    repeat (30) @(posedge ref_clk);
    rdQ.push_back(32'h3);
    h.rd(der_pkg::ADDR_IRQ_STAT);
    check("irq overflow", 32'h1, {31'h0, irq});
    steps();
    $display("Test queue overflow done");
    stop_test();
  end
endmodule
